// *** rx_status_ctrl.v ***
// Receive frame parser, status word builder, status FIFO and halt control
`timescale 1ns/100ps
`include "rx_status_defines.vh"

module rx_status_ctrl (
	// Clock and reset
	input  wire        clk_i,
	input  wire        rst_b_i,
	// MII receive pins
	input  wire [3:0]  mii_rxd_i,
	input  wire        mii_rx_dv_i,
	input  wire        mii_rx_er_i,
	input  wire        mii_col_i,
	// Control bits from the MAC control register
	input  wire        receive_enable_i,
	input  wire        pass_bad_frames_i,
	// Address filter verdict, valid at frame end
	input  wire        filter_fail_i,
	// Host side of the FIFOs
	input  wire        stat_rd_i,
	input  wire        stat_flush_i,
	input  wire        data_underrun_i,
	input  wire        fault_clr_i,
	// Frame data toward the data FIFO
	output reg  [7:0]  data_byte_o,
	output reg         data_valid_o,
	output reg         frame_done_o,
	output reg         frame_drop_o,
	// Status FIFO read port
	output wire [31:0] stat_word_o,
	output wire        stat_empty_o,
	output reg  [4:0]  stat_count_o,
	// Receiver state and events
	output reg         receive_fault_flag_o,
	output reg         receive_halt_pulse_o,
	output wire        receive_active_o
);

	// Pin synchronisers
	reg  [6:0]  pin_s1_r;
	reg  [6:0]  pin_s2_r;
	wire [3:0]  rxd;
	wire        dv;
	wire        er;
	wire        col;

	// Frame parser state
	reg  [1:0]  state_r;
	reg  [1:0]  state_nxt;
	reg         phase_r;
	reg  [3:0]  lo_nib_r;
	reg  [13:0] byte_cnt_r;
	reg         bcast_r;
	reg         mcast_r;
	reg  [7:0]  type_hi_r;
	reg  [7:0]  type_lo_r;
	reg         mii_err_r;
	reg         lcol_r;
	reg         wdog_r;
	reg  [31:0] crc_r;
	reg  [31:0] crc_byte_r;
	wire [31:0] crc_step;
	wire [7:0]  cur_byte;
	wire        byte_done;
	wire        frame_end;
	wire        wdog_hit;

	// Status word terms
	wire        runt;
	wire        too_long;
	wire [15:0] type_val;
	wire [15:0] payload;
	wire        has_hdr;
	wire        ftype;
	wire        size_bad;
	wire        drib;
	wire        crc_err;
	wire        err_sum;
	reg  [31:0] stat_nxt;
	wire        keep_frame;

	// Status FIFO
	reg  [`STAT_AW:0] wr_ptr_r;
	reg  [`STAT_AW:0] rd_ptr_r;
	wire        stat_full;
	wire        push_req;
	wire        push_ok;
	wire        pop_ok;

	// Halt tracking
	reg         halted_r;
	wire        halted_nxt;

	// Two flops ahead of any logic on the pin inputs
	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pin_s1_r <= 7'h00;
			pin_s2_r <= 7'h00;
		end else begin
			pin_s1_r <= {mii_col_i, mii_rx_er_i, mii_rx_dv_i, mii_rxd_i};
			pin_s2_r <= pin_s1_r;
		end
	end

	assign rxd = pin_s2_r[3:0];
	assign dv  = pin_s2_r[4];
	assign er  = pin_s2_r[5];
	assign col = pin_s2_r[6];

	rx_crc_nibble i_rx_crc_nibble (
		.crc_i (crc_r),
		.nib_i (rxd),
		.crc_o (crc_step)
	);

	// Byte completes on the second nibble of a pair
	assign cur_byte  = {rxd, lo_nib_r};
	assign byte_done = (state_r == `RS_DATA) & dv & phase_r & ~wdog_hit;
	assign wdog_hit  = (byte_cnt_r >= `WDOG_BYTES);
	// End is seen a cycle after the last byte went out, two after a dribble nibble, so data leads
	assign frame_end = (state_r == `RS_DATA) & (~dv | wdog_hit);

	// Next state; a new frame only starts while reception is enabled
	always @* begin
		state_nxt = state_r;
		case (state_r)
		`RS_IDLE: begin
			if (dv & receive_enable_i)
				state_nxt = `RS_PRE;
		end
		`RS_PRE: begin
			if (!dv)
				state_nxt = `RS_IDLE;
			else if (rxd == `NIB_SFD)
				state_nxt = `RS_DATA;
		end
		`RS_DATA: begin
			if (wdog_hit)
				state_nxt = `RS_WAIT;
			else if (!dv)
				state_nxt = `RS_IDLE;
		end
		`RS_WAIT: begin
			if (!dv)
				state_nxt = `RS_IDLE;
		end
		default: state_nxt = `RS_IDLE;
		endcase
	end

	// Per-frame accumulators, cleared when the start delimiter arrives
	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_r    <= `RS_IDLE;
			phase_r    <= 1'b0;
			lo_nib_r   <= 4'h0;
			byte_cnt_r <= 14'h0000;
			bcast_r    <= 1'b0;
			mcast_r    <= 1'b0;
			type_hi_r  <= 8'h00;
			type_lo_r  <= 8'h00;
			mii_err_r  <= 1'b0;
			lcol_r     <= 1'b0;
			wdog_r     <= 1'b0;
			crc_r      <= `CRC_INIT;
			crc_byte_r <= `CRC_INIT;
		end else begin
			state_r <= state_nxt;
			if (state_r == `RS_PRE) begin
				phase_r    <= 1'b0;
				byte_cnt_r <= 14'h0000;
				bcast_r    <= 1'b1;
				mcast_r    <= 1'b0;
				type_hi_r  <= 8'h00;
				type_lo_r  <= 8'h00;
				mii_err_r  <= er;
				lcol_r     <= 1'b0;
				wdog_r     <= 1'b0;
				crc_r      <= `CRC_INIT;
				crc_byte_r <= `CRC_INIT;
			end else if ((state_r == `RS_DATA) & dv & ~wdog_hit) begin
				phase_r <= ~phase_r;
				crc_r   <= crc_step;
				if (er)
					mii_err_r <= 1'b1;
				if (col & (byte_cnt_r >= `RUNT_BYTES))
					lcol_r <= 1'b1;
				if (!phase_r)
					lo_nib_r <= rxd;
			end
			if (byte_done) begin
				// No truncation past the long-frame size; count saturates
				if (byte_cnt_r != `BYTE_CNT_MAX)
					byte_cnt_r <= byte_cnt_r + 14'h0001;
				crc_byte_r <= crc_step;
				if (byte_cnt_r < `IDX_DA_END)
					bcast_r <= bcast_r & (cur_byte == `BYTE_ONES);
				if (byte_cnt_r == 14'h0000)
					mcast_r <= cur_byte[0];
				if (byte_cnt_r == `IDX_TYPE_HI)
					type_hi_r <= cur_byte;
				if (byte_cnt_r == `IDX_TYPE_LO)
					type_lo_r <= cur_byte;
			end
			if ((state_r == `RS_DATA) & wdog_hit)
				wdog_r <= 1'b1;
		end
	end

	// Status terms, all settled from registers at the end cycle
	assign runt     = (byte_cnt_r < `RUNT_BYTES);
	assign too_long = (byte_cnt_r > `MAX_FRAME);
	assign type_val = {type_hi_r, type_lo_r};
	assign has_hdr  = (byte_cnt_r >= `HDR_BYTES);
	assign ftype    = has_hdr & (type_val > `TYPE_LIMIT);
	assign payload  = {2'b00, byte_cnt_r} - `LEN_OVERHEAD;
	// Short payloads are padded, so compare against the minimum instead
	assign size_bad = has_hdr & ~ftype &
		((type_val >= `MIN_PAYLOAD) ? (payload != type_val)
		                            : (payload != `MIN_PAYLOAD));
	// An odd nibble is four dribble bits, enough in either speed mode
	assign drib     = phase_r & ~lcol_r;
	// CRC checked at the last whole byte so dribble bits do not spoil it
	assign crc_err  = (crc_byte_r != `CRC_RESIDUE) | mii_err_r;
	assign err_sum  = runt | too_long | lcol_r | crc_err;

	// Reserved positions stay at their zero default
	always @* begin
		stat_nxt = 32'h00000000;
		stat_nxt[`ST_FILT]                 = filter_fail_i;
		stat_nxt[`ST_LEN_HI:`ST_LEN_LO]    = byte_cnt_r;
		stat_nxt[`ST_ERR_SUM]              = err_sum;
		stat_nxt[`ST_BCAST]                = bcast_r;
		stat_nxt[`ST_SIZE_BAD]             = size_bad;
		stat_nxt[`ST_RUNT]                 = runt;
		stat_nxt[`ST_MCAST]                = mcast_r & ~bcast_r;
		stat_nxt[`ST_LONG]                 = too_long;
		stat_nxt[`ST_LCOL]                 = lcol_r;
		stat_nxt[`ST_FTYPE]                = ftype;
		stat_nxt[`ST_WDOG]                 = wdog_r | wdog_hit;
		stat_nxt[`ST_MIIERR]               = mii_err_r;
		stat_nxt[`ST_DRIB]                 = drib;
		stat_nxt[`ST_CRC]                  = crc_err;
	end

	// Runts are dropped unless software asked to see bad frames
	assign keep_frame = ~runt | pass_bad_frames_i;

	// Data bytes and frame end markers toward the data FIFO
	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			data_byte_o  <= 8'h00;
			data_valid_o <= 1'b0;
			frame_done_o <= 1'b0;
			frame_drop_o <= 1'b0;
		end else begin
			data_valid_o <= byte_done;
			if (byte_done)
				data_byte_o <= cur_byte;
			frame_done_o <= frame_end & keep_frame;
			frame_drop_o <= frame_end & ~keep_frame;
		end
	end

	// Status FIFO bookkeeping; push follows the last data byte
	assign push_req  = frame_end & keep_frame;
	assign stat_full = (wr_ptr_r[`STAT_AW] != rd_ptr_r[`STAT_AW]) &
		(wr_ptr_r[`STAT_AW-1:0] == rd_ptr_r[`STAT_AW-1:0]);
	assign stat_empty_o = (wr_ptr_r == rd_ptr_r);
	assign push_ok = push_req & ~stat_full;
	// An empty read returns stale data and is flagged, never advanced
	assign pop_ok  = stat_rd_i & ~stat_empty_o;

	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wr_ptr_r     <= 5'h00;
			rd_ptr_r     <= 5'h00;
			stat_count_o <= 5'h00;
		end else if (stat_flush_i) begin
			// Flush is meant for a stopped receiver only
			wr_ptr_r     <= 5'h00;
			rd_ptr_r     <= 5'h00;
			stat_count_o <= 5'h00;
		end else begin
			if (push_ok)
				wr_ptr_r <= wr_ptr_r + 5'h01;
			if (pop_ok)
				rd_ptr_r <= rd_ptr_r + 5'h01;
			stat_count_o <= (wr_ptr_r + {4'h0, push_ok}) -
				(rd_ptr_r + {4'h0, pop_ok});
		end
	end

	rx_stat_mem i_rx_stat_mem (
		.clk_i     (clk_i),
		.rst_b_i   (rst_b_i),
		.wr_en_i   (push_ok),
		.wr_addr_i (wr_ptr_r[`STAT_AW-1:0]),
		.wr_data_i (stat_nxt),
		.rd_en_i   (pop_ok),
		.rd_addr_i (rd_ptr_r[`STAT_AW-1:0]),
		.rd_data_o (stat_word_o)
	);

	// Sticky fault; a new event in the clear cycle wins over the clear
	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			receive_fault_flag_o <= 1'b0;
		else
			receive_fault_flag_o <= (receive_fault_flag_o & ~fault_clr_i) |
				data_underrun_i | (stat_rd_i & stat_empty_o) |
				(push_req & stat_full);
	end
	// Nothing above gates the parser on the fault flag

	// Halted once enable is low and no frame is in flight
	assign halted_nxt = ~receive_enable_i & (state_r == `RS_IDLE);
	assign receive_active_o = ~halted_r;

	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			halted_r             <= 1'b0;
			receive_halt_pulse_o <= 1'b0;
		end else begin
			halted_r             <= halted_nxt;
			receive_halt_pulse_o <= halted_nxt & ~halted_r;
		end
	end

endmodule

// *** rx_status_defines.vh ***
// Constants for the receive status word and receiver control logic
`ifndef RX_STATUS_DEFINES_VH
`define RX_STATUS_DEFINES_VH

// Status word bit positions
`define ST_FILT      30
`define ST_LEN_HI    29
`define ST_LEN_LO    16
`define ST_ERR_SUM   15
`define ST_BCAST     13
`define ST_SIZE_BAD  12
`define ST_RUNT      11
`define ST_MCAST     10
`define ST_LONG      7
`define ST_LCOL      6
`define ST_FTYPE     5
`define ST_WDOG      4
`define ST_MIIERR    3
`define ST_DRIB      2
`define ST_CRC       1

// Frame size limits in bytes
`define RUNT_BYTES   14'h0040
`define MAX_FRAME    14'h05ee
`define HDR_BYTES    14'h000e
`define WDOG_BYTES   14'h0800
`define LEN_OVERHEAD 16'h0012
`define MIN_PAYLOAD  16'h002e
`define TYPE_LIMIT   16'h05dc
`define BYTE_CNT_MAX 14'h3fff
`define IDX_DA_END   14'h0006
`define IDX_TYPE_HI  14'h000c
`define IDX_TYPE_LO  14'h000d

// CRC, reflected form; residue seen after the FCS has been shifted in
`define CRC_INIT     32'hffffffff
`define CRC_POLY     32'hedb88320
`define CRC_RESIDUE  32'hdebb20e3

// Line nibble and byte values
`define NIB_SFD      4'hd
`define BYTE_ONES    8'hff

// Status FIFO geometry
`define STAT_AW      4
`define STAT_DEPTH   16

// Receive state codes
`define RS_IDLE      2'h0
`define RS_PRE       2'h1
`define RS_DATA      2'h2
`define RS_WAIT      2'h3

`endif

// *** rx_crc_nibble.v ***
// Nibble-wide reflected CRC-32 step for the receive path
`timescale 1ns/100ps
`include "rx_status_defines.vh"

module rx_crc_nibble (
	// Current remainder and incoming nibble
	input  wire [31:0] crc_i,
	input  wire [3:0]  nib_i,
	// Updated remainder
	output reg  [31:0] crc_o
);

	integer k;

	// Shift four bits, least significant first as they arrive on the line
	always @* begin
		crc_o = crc_i;
		for (k = 0; k < 4; k = k + 1) begin
			if (crc_o[0] ^ nib_i[k])
				crc_o = {1'b0, crc_o[31:1]} ^ `CRC_POLY;
			else
				crc_o = {1'b0, crc_o[31:1]};
		end
	end

endmodule

// *** rx_stat_mem.v ***
// Storage array for the receive status FIFO with registered read data
`timescale 1ns/100ps
`include "rx_status_defines.vh"

module rx_stat_mem (
	// Clock and reset
	input  wire                clk_i,
	input  wire                rst_b_i,
	// Write side
	input  wire                wr_en_i,
	input  wire [`STAT_AW-1:0] wr_addr_i,
	input  wire [31:0]         wr_data_i,
	// Read side
	input  wire                rd_en_i,
	input  wire [`STAT_AW-1:0] rd_addr_i,
	output reg  [31:0]         rd_data_o
);

	reg [31:0] mem_r [0:`STAT_DEPTH-1];

	// Array itself is not reset; pointers decide what is valid
	always @(posedge clk_i) begin
		if (wr_en_i)
			mem_r[wr_addr_i] <= wr_data_i;
	end

	// Read data held until the next read
	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			rd_data_o <= 32'h00000000;
		else if (rd_en_i)
			rd_data_o <= mem_r[rd_addr_i];
	end

endmodule

// *** rx_host_model.sv ***
// Host model that drains the receive status FIFO one word at a time
`timescale 1ns/100ps
module rx_host_model (
	// Clock and reset
	input  wire clk_i,
	input  wire rst_b_i,
	// Pacing and FIFO state
	input  wire en_i,
	input  wire slow_i,
	input  wire stat_empty_i,
	// Pop strobe
	output reg  stat_rd_o
);
	reg [3:0] gap_r;

	// Pops only a word that is there; the gap after each pop lets the
	// empty flag catch up, so the host never reads past the last word
	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			stat_rd_o <= 1'b0;
			gap_r     <= 4'h0;
		end else begin
			gap_r     <= gap_r + 4'h1;
			stat_rd_o <= en_i && !stat_empty_i && !stat_rd_o &&
				(!slow_i || gap_r == 4'h0);
		end
	end
endmodule

// *** rx_status_ctrl_assertions.sv ***
// Concurrent checks on the receive status and receiver control ports
`timescale 1ns/100ps
module rx_status_ctrl_assertions (
	// Clock and reset
	input wire logic        clk_i,
	input wire logic        rst_b_i,
	// Inputs watched
	input wire logic        pass_bad_frames_i,
	input wire logic        stat_rd_i,
	input wire logic        stat_flush_i,
	input wire logic        data_underrun_i,
	input wire logic        fault_clr_i,
	// Outputs watched
	input wire logic        frame_done_o,
	input wire logic        frame_drop_o,
	input wire logic [31:0] stat_word_o,
	input wire logic        stat_empty_o,
	input wire logic [4:0]  stat_count_o,
	input wire logic        receive_fault_flag_o,
	input wire logic        receive_halt_pulse_o,
	input wire logic        receive_active_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	// A pop that really takes a word
	wire pop = stat_rd_i && !stat_empty_o && !stat_flush_i;

	chk_halt_follows: assert property ($fell(receive_active_o) |->
		receive_halt_pulse_o) else $error("halt pulse missing");
	chk_halt_single: assert property (receive_halt_pulse_o |=>
		!receive_halt_pulse_o && !receive_active_o)
		else $error("halt pulse too long");
	chk_fault_sticky: assert property (receive_fault_flag_o &&
		!fault_clr_i && !$past(fault_clr_i) |=> receive_fault_flag_o)
		else $error("fault flag dropped");
	chk_fault_empty: assert property (stat_rd_i && stat_empty_o &&
		!stat_flush_i |-> ##[1:2] receive_fault_flag_o)
		else $error("no fault on empty pop");
	chk_fault_under: assert property (data_underrun_i |->
		##[1:2] receive_fault_flag_o) else $error("no fault on underrun");
	chk_pop_count: assert property (pop |=> stat_count_o ==
		$past(stat_count_o) - 5'h1 + {4'h0, frame_done_o})
		else $error("count wrong after pop");
	chk_push_count: assert property (frame_done_o &&
		!$past(stat_rd_i) && !$past(stat_flush_i) &&
		$past(stat_count_o) != 5'h10 |->
		stat_count_o == $past(stat_count_o) + 5'h1)
		else $error("count wrong after push");
	chk_word_zero: assert property (pop |=> !stat_word_o[31] &&
		!stat_word_o[14] && stat_word_o[9:8] == 2'b00 && !stat_word_o[0])
		else $error("reserved status bit set");
	chk_word_summary: assert property (pop |=> stat_word_o[15] ==
		(stat_word_o[11] | stat_word_o[7] | stat_word_o[6] | stat_word_o[1]))
		else $error("error summary wrong");
	chk_drib_col: assert property (pop |=>
		!(stat_word_o[6] && stat_word_o[2])) else $error("dribble with col");
	chk_drop_runt: assert property (frame_drop_o |->
		!pass_bad_frames_i && !frame_done_o) else $error("bad drop");
endmodule

bind rx_status_ctrl rx_status_ctrl_assertions i_rx_status_ctrl_assertions (
	.clk_i(clk_i), .rst_b_i(rst_b_i), .pass_bad_frames_i(pass_bad_frames_i),
	.stat_rd_i(stat_rd_i), .stat_flush_i(stat_flush_i),
	.data_underrun_i(data_underrun_i), .fault_clr_i(fault_clr_i),
	.frame_done_o(frame_done_o), .frame_drop_o(frame_drop_o),
	.stat_word_o(stat_word_o), .stat_empty_o(stat_empty_o),
	.stat_count_o(stat_count_o), .receive_fault_flag_o(receive_fault_flag_o),
	.receive_halt_pulse_o(receive_halt_pulse_o),
	.receive_active_o(receive_active_o));

// *** test_rx_status_ctrl.sv ***
// Testbench: MII frames in, status words and receiver events checked
`timescale 1ns/100ps
module test_rx_status_ctrl;
	reg         clk_i, rst_b_i, mii_rx_dv_i, mii_rx_er_i, mii_col_i;
	reg  [3:0]  mii_rxd_i;
	reg         receive_enable_i, pass_bad_frames_i, filter_fail_i, tb_rd;
	reg         stat_flush_i, data_underrun_i, fault_clr_i, host_en;
	reg         host_slow, rd_d = 1'b0;
	wire        host_rd, data_valid_o, frame_done_o, frame_drop_o;
	wire        stat_empty_o, receive_fault_flag_o, receive_halt_pulse_o;
	wire        receive_active_o;
	wire [7:0]  data_byte_o;
	wire [31:0] stat_word_o;
	wire [4:0]  stat_count_o;
	wire        stat_rd_i = host_rd | tb_rd;
	reg  [31:0] exp_q[$], msk_q[$], m, s, e;
	reg  [7:0]  byte_q[$], fr[0:2199];
	integer     mismatches = 0, num_checks = 0, ndrop = 0, nhalt = 0;
	integer     seed, i;

	rx_status_ctrl i_rx_status_ctrl (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .mii_rxd_i(mii_rxd_i),
		.mii_rx_dv_i(mii_rx_dv_i), .mii_rx_er_i(mii_rx_er_i),
		.mii_col_i(mii_col_i), .receive_enable_i(receive_enable_i),
		.pass_bad_frames_i(pass_bad_frames_i), .filter_fail_i(filter_fail_i),
		.stat_rd_i(stat_rd_i), .stat_flush_i(stat_flush_i),
		.data_underrun_i(data_underrun_i), .fault_clr_i(fault_clr_i),
		.data_byte_o(data_byte_o), .data_valid_o(data_valid_o),
		.frame_done_o(frame_done_o), .frame_drop_o(frame_drop_o),
		.stat_word_o(stat_word_o), .stat_empty_o(stat_empty_o),
		.stat_count_o(stat_count_o),
		.receive_fault_flag_o(receive_fault_flag_o),
		.receive_halt_pulse_o(receive_halt_pulse_o),
		.receive_active_o(receive_active_o));

	rx_host_model i_rx_host_model (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.en_i(host_en), .slow_i(host_slow), .stat_empty_i(stat_empty_o),
		.stat_rd_o(host_rd));

	// Free-running 25 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	task check(input [31:0] seen, exp);
		begin
			num_checks = num_checks + 1;
			if (seen !== exp) begin
				mismatches = mismatches + 1;
				$display("CHECK FAILED at %0t: saw %h, expected %h", $time,
					seen, exp);
			end
		end
	endtask

	task report_and_stop;
		begin
			$display("checks %0d, mismatches %0d", num_checks, mismatches);
			if (mismatches == 0 && num_checks > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask

	// Reflected CRC-32 over the first n frame bytes, kept apart from design
	function [31:0] crc(input integer n);
		integer j, b;
		reg [31:0] c;
		begin
			c = 32'hffffffff;
			for (j = 0; j < n; j = j + 1)
				for (b = 0; b < 8; b = b + 1)
					c = (c >> 1) ^ ((c[0] ^ fr[j][b]) ? 32'hedb88320 : 32'h0);
			crc = ~c;
		end
	endfunction

	// Build a frame with a good FCS unless bad is set, note the outcome, drive it nibblewise
	task send(input integer n, k, t, input bad, er, col, dr, ff);
		reg [31:0] c, w;
		reg        rn, ft, kp, wd;
		reg  [13:0] ln;
		begin
			for (i = 0; i < n; i = i + 1)
				fr[i] = 8'($random(seed));
			for (i = 0; i < 6; i = i + 1)
				fr[i] = k == 1 ? 8'hff : i ? fr[i] : k == 2 ? 8'h01 : 8'h02;
			fr[12] = t[15:8];
			fr[13] = t[7:0];
			c = crc(n - 4);
			for (i = 0; i < 4; i = i + 1)
				fr[n - 4 + i] = c[8 * i +: 8];
			fr[n - 1] = fr[n - 1] ^ {7'h0, bad};
			rn = n < 64;
			wd = n >= 2048;
			ln = wd ? 14'h0800 : n[13:0];
			ft = t > 1500;
			kp = (!rn || pass_bad_frames_i) && receive_enable_i;
			w = {1'b0, ff, ln, rn | n > 1518 | col | bad | er, 1'b0,
				k == 1, !ft && n - 18 != (t < 46 ? 46 : t), rn, k == 2,
				2'h0, n > 1518, col, ft, wd, er, dr & !col, bad | er, 1'b0};
			if (kp) begin
				exp_q.push_back(w);
				msk_q.push_back(rn | col | wd ? 32'hfffffffd
					: 32'hffffffff);
			end
			host_slow = 1'($random(seed));
			filter_fail_i = ff;
			mii_rx_dv_i = 1'b1;
			mii_rxd_i = 4'h5;
			repeat (2) @(negedge clk_i);
			mii_rxd_i = 4'hd;
			for (i = 0; i < 2 * n + dr; i = i + 1) begin
				@(negedge clk_i);
				mii_rxd_i = i < 2 * n ? fr[i / 2][4 * (i % 2) +: 4] : 4'h9;
				mii_rx_er_i = er && i == 40;
				mii_col_i = col && i > 140;
				if (kp && i % 2 && i < 4096)
					byte_q.push_back(fr[i / 2]);
			end
			@(negedge clk_i);
			mii_rx_dv_i = 1'b0;
			mii_rx_er_i = 1'b0;
			mii_col_i = 1'b0;
			mii_rxd_i = ~mii_rxd_i;
			repeat (12) @(negedge clk_i);
			filter_fail_i = 1'b0;
		end
	endtask

	task wait_q;
		integer j;
		begin
			for (j = 0; j < 4000 && exp_q.size() > 0; j = j + 1)
				@(negedge clk_i);
			check(exp_q.size(), 0);
			repeat (4) @(negedge clk_i);
		end
	endtask

	task clr_fault;
		begin
			fault_clr_i = 1'b1;
			@(negedge clk_i);
			fault_clr_i = 1'b0;
			repeat (2) @(negedge clk_i);
			check(receive_fault_flag_o, 0);
		end
	endtask

	// Compare popped words and received bytes against the oldest notes
	always @(posedge clk_i) begin
		rd_d <= stat_rd_i && !stat_empty_o && !stat_flush_i;
		if (rd_d && exp_q.size() > 0) begin
			m = msk_q.pop_front();
			s = stat_word_o & m;
			e = exp_q.pop_front() & m;
			check(s[31:16], e[31:16]);
			check(s[15:8], e[15:8]);
			check(s[7:0], e[7:0]);
		end
		if (data_valid_o && byte_q.size() > 0)
			check({24'h0, data_byte_o}, {24'h0, byte_q.pop_front()});
		ndrop = ndrop + frame_drop_o;
		nhalt = nhalt + receive_halt_pulse_o;
	end

	// Watchdog against a hang
	initial begin
		#2000000;
		mismatches = mismatches + 1;
		report_and_stop;
	end

	// Reset, then frame fields, faults, overrun and halt with flush
	initial begin
		seed = 7999;
		{rst_b_i, mii_rx_dv_i, mii_rx_er_i, mii_col_i, tb_rd} = 5'h0;
		{pass_bad_frames_i, filter_fail_i, stat_flush_i} = 3'h0;
		{data_underrun_i, fault_clr_i, host_slow} = 3'h0;
		{receive_enable_i, host_en} = 2'h3;
		mii_rxd_i = 4'h0;
		repeat (16) @(negedge clk_i);
		rst_b_i = 1'b1;
		repeat (2) @(negedge clk_i);
		send(64, 0, 16'h0800, 0, 0, 0, 0, 0);
		send(64, 1, 46, 0, 0, 0, 0, 0);
		send(100, 2, 60, 1, 0, 0, 0, 0);
		send(70, 0, 52, 0, 1, 0, 1, 1);
		send(80, 0, 16'h0800, 0, 0, 1, 1, 0);
		send(1600, 0, 16'h0800, 0, 0, 0, 0, 0);
		send(2100, 0, 16'h0800, 0, 0, 0, 0, 0);
		pass_bad_frames_i = 1'b1;
		send(20, 0, 16'h0800, 0, 0, 0, 0, 0);
		pass_bad_frames_i = 1'b0;
		send(20, 0, 16'h0800, 0, 0, 0, 0, 0);
		wait_q;
		check(ndrop, 1);
		$display("status word tests done");
		tb_rd = 1'b1;
		@(negedge clk_i);
		tb_rd = 1'b0;
		repeat (2) @(negedge clk_i);
		check(receive_fault_flag_o, 1);
		clr_fault;
		data_underrun_i = 1'b1;
		@(negedge clk_i);
		data_underrun_i = 1'b0;
		repeat (2) @(negedge clk_i);
		check(receive_fault_flag_o, 1);
		clr_fault;
		host_en = 1'b0;
		repeat (17)
			send(64, 0, 16'h0800, 0, 0, 0, 0, 0);
		void'(exp_q.pop_back());
		void'(msk_q.pop_back());
		check(stat_count_o, 16);
		check(receive_fault_flag_o, 1);
		host_en = 1'b1;
		send(64, 2, 16'h0800, 0, 0, 0, 0, 0);
		wait_q;
		clr_fault;
		$display("fault tests done");
		host_en = 1'b0;
		send(64, 1, 16'h0800, 0, 0, 0, 0, 0);
		receive_enable_i = 1'b0;
		for (i = 0; i < 100 && nhalt == 0; i = i + 1)
			@(negedge clk_i);
		check(nhalt, 1);
		check(receive_active_o, 0);
		stat_flush_i = 1'b1;
		@(negedge clk_i);
		stat_flush_i = 1'b0;
		@(negedge clk_i);
		check(stat_count_o, 0);
		exp_q.delete();
		msk_q.delete();
		send(64, 0, 16'h0800, 0, 0, 0, 0, 0);
		check(stat_count_o, 0);
		receive_enable_i = 1'b1;
		host_en = 1'b1;
		send(64, 0, 16'h0800, 0, 0, 0, 0, 1);
		wait_q;
		check(exp_q.size() + byte_q.size(), 0);
		$display("halt tests done");
		report_and_stop;
	end
endmodule
